// >>> src/nipu_pkg.sv
// Constants, types and register map of the nested interrupt priority unit
package nipu_pkg;

  // ------------------------------------------------------------------
  // Vector set
  // ------------------------------------------------------------------
  localparam int          NUM_VEC     = 14;
  localparam int          VEC_W       = 4;
  localparam int          TLI_VEC     = 0;
  localparam int          TB_VEC      = 1;
  localparam int          UNUSED_VEC  = 6;
  localparam int          SPI_VEC     = 7;
  localparam int          ART_VEC     = 13;
  localparam int          NUM_PRIO    = 4;
  localparam int          VEC_PER_REG = 4;

  // ------------------------------------------------------------------
  // Priority pair encodings {hi, lo}
  // ------------------------------------------------------------------
  localparam logic [1:0]  PAIR_L0     = 2'h2;
  localparam logic [1:0]  PAIR_L1     = 2'h1;
  localparam logic [1:0]  PAIR_L2     = 2'h0;
  localparam logic [1:0]  PAIR_L3     = 2'h3;
  localparam logic [2:0]  LVL_TOP     = 3'h4;
  localparam int          CC_HI_BIT   = 5;
  localparam int          CC_LO_BIT   = 3;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int          AW          = 5;
  localparam logic [AW-1:0] ADDR_PRIO0  = 5'h00;
  localparam logic [AW-1:0] ADDR_PRIO1  = 5'h04;
  localparam logic [AW-1:0] ADDR_PRIO2  = 5'h08;
  localparam logic [AW-1:0] ADDR_PRIO3  = 5'h0C;
  localparam logic [AW-1:0] ADDR_STATUS = 5'h10;
  localparam logic [7:0]  PRIO_RST    = 8'hFF;
  localparam logic [7:0]  PRIO3_RO    = 8'hF0;

  // ------------------------------------------------------------------
  // Vector table
  // ------------------------------------------------------------------
  localparam logic [15:0] VEC_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP    = 16'hFFFC;
  localparam logic [15:0] VEC_BASE    = 16'hFFFA;
  localparam logic [13:0] WAKE_FIXED  = 14'h003F;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       irq_enable_instr;
    logic       sim;
    logic       halt;
    logic       wait_for_irq_instr;
    logic       trap;
    logic       irq_return_instr;
    logic       pop_condition_codes;
    logic [7:0] cc_val;
  } nipu_cpu_evt_s;

  typedef enum logic [1:0] {
    BUS_WAIT = 2'h1,
    BUS_DONE = 2'h2
  } nipu_bus_e;

endpackage

// >>> src/nipu_top.sv
// Nested interrupt priority unit: priority registers, arbitration, level tracking
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// RULE_01: Interrupt entry loads current priority bits from the serviced vector's pair.
// RULE_02: Pair codes: level0=10, level1=01, level2=00, level3=11 (all maskables off).
// RULE_03: Top-level interrupt, trap and reset still preempt level 3 code.
// RULE_04: Priority registers read/write; upper nibble of fourth is read-only ones.
// RULE_05: All priority registers reset to all ones.
// RULE_06: Vector x pair sits in register x/4 at bits 2*(x mod 4)+1:+0.
// RULE_07: Top-level interrupt pair is stored but ignored by arbitration.
// RULE_08: Writing pattern 10 into a pair leaves that pair unchanged.
// RULE_09: Servicing top-level interrupt, reset or trap sets priority bits to 11.
// RULE_10: Raised priority of a pending in-service vector causes re-entry.
// RULE_11: Enable, halt, wait load 10; disable and trap load 11.
// RULE_12: Interrupt return restores the stacked current priority bits.
// RULE_13: Jump flags report priority equal to 11 and different from 11.
// RULE_14: Priority instructions inside routines change level until next such event.
// RULE_15: Vector table: reset FFFE, trap FFFC, maskables descending to FFE0.
// RULE_16: Fixed hardware priority falls with vector number.
// RULE_17: Reset, top-level, time base, four port vectors wake; SPI only slave.
// RULE_18: Timer wakes only on external clock; flash active halt wakes on time base.
// RULE_19: Highest software level wins, ties go to fixed hardware order.
// RULE_20: Maskable request serviced only if enabled and above current level.
// RULE_21: Entry happens after the CPU finishes its instruction and stacks registers.
// RULE_22: Current priority comes up as 11 after reset.
// RULE_23: Level comparison is strict so equal levels never nest.
module nipu_top
  import nipu_pkg::*;
#(
  parameter int N_VEC        = NUM_VEC,
  parameter bit FLASH_DEVICE = 1'b1
) (
  input  wire logic                ref_clk_in,            // CPU clock
  input  wire logic                rst_b_in,              // Async reset, active low
  input  wire logic [AW-1:0]       avs_address_in,        // Register byte address
  input  wire logic                avs_read_in,           // Read request
  input  wire logic                avs_write_in,          // Write request
  input  wire logic [31:0]         avs_writedata_in,      // Write data
  input  wire logic [3:0]          avs_byteenable_in,     // Byte lanes
  output logic      [31:0]         avs_readdata_out,      // Read data
  output logic                     avs_waitrequest_out,   // Slave stall
  input  wire logic [N_VEC-1:0]    irq_req_in,            // Latched source flags
  input  wire logic [N_VEC-1:0]    irq_en_in,             // Source enables
  input  wire nipu_cpu_evt_s       cpu_evt_in,            // Instruction events
  input  wire logic                irq_entry_in,          // CPU entered routine
  input  wire logic                halt_mode_in,          // Core in halt
  input  wire logic                active_halt_in,        // Halt is active halt
  input  wire logic                spi_slave_in,          // SPI in slave mode
  input  wire logic                art_ext_clk_in,        // Timer externally clocked
  output logic                     irq_req_out,           // Request to core
  output logic      [VEC_W-1:0]    irq_vec_out,           // Requested vector
  output logic      [15:0]         irq_addr_out,          // Requested vector address
  output logic      [N_VEC-1:0]    irq_ack_out,           // Entry acknowledge pulse
  output logic      [15:0]         svc_addr_out,          // Routine being entered
  output logic                     wake_out,              // Halt exit request
  output logic                     cur_prio_hi_out,       // Current priority hi
  output logic                     cur_prio_lo_out,       // Current priority lo
  output logic                     jump_if_masked_out,    // Level is 3
  output logic                     jump_if_unmasked_out   // Level below 3
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (N_VEC != NUM_VEC) begin : g_chk
    $error("nipu_top supports exactly fourteen maskable vectors");
  end

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [1:0] pair2lvl(input logic [1:0] p);
    case (p)
      PAIR_L0: pair2lvl = 2'h0;
      PAIR_L1: pair2lvl = 2'h1;
      PAIR_L2: pair2lvl = 2'h2;
      default: pair2lvl = 2'h3;
    endcase
  endfunction

  function automatic logic [15:0] vec_addr(input logic [VEC_W-1:0] v);
    vec_addr = VEC_BASE - {11'h000, v, 1'b0}; // RULE_15
  endfunction

  function automatic logic [7:0] merge_prio(input logic [7:0] old_v,
                                            input logic [7:0] new_v);
    merge_prio = old_v;
    for (int k = 0; k < VEC_PER_REG; k++) begin
      if (new_v[2*k +: 2] != PAIR_L0) begin // RULE_08
        merge_prio[2*k +: 2] = new_v[2*k +: 2];
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0]              prio_ff [NUM_PRIO];
  logic [2*N_VEC-1:0]      prio_flat;
  logic [1:0]              cc_pair_ff;
  logic [1:0]              nxt_cc_pair;
  nipu_bus_e               bus_st_ff;
  logic                    bus_req;
  logic                    bus_done;
  logic [31:0]             nxt_rdata;
  logic [N_VEC-1:0]        wake_mask;
  logic [N_VEC-1:0]        cand;
  logic                    best_vld;
  logic [VEC_W-1:0]        best_idx;
  logic [2:0]              best_lvl;
  logic [1:0]              best_pair;
  logic [1:0]              irq_pair_ff;
  logic                    entry_ok;

  // ------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then done
  // ------------------------------------------------------------------
  assign bus_req  = avs_read_in | avs_write_in;
  assign bus_done = bus_req & (bus_st_ff == BUS_DONE);

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_st_ff           <= BUS_WAIT;
      avs_waitrequest_out <= 1'b1;
    end else begin
      case (bus_st_ff)
        BUS_WAIT: begin
          if (bus_req) begin
            bus_st_ff           <= BUS_DONE;
            avs_waitrequest_out <= 1'b0;
          end
        end
        BUS_DONE: begin
          bus_st_ff           <= BUS_WAIT;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          bus_st_ff           <= BUS_WAIT;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_in)
      ADDR_PRIO0:  nxt_rdata[7:0] = prio_ff[0];
      ADDR_PRIO1:  nxt_rdata[7:0] = prio_ff[1];
      ADDR_PRIO2:  nxt_rdata[7:0] = prio_ff[2];
      ADDR_PRIO3:  nxt_rdata[7:0] = prio_ff[3] | PRIO3_RO; // RULE_04
      ADDR_STATUS: begin
        nxt_rdata[1:0]  = cc_pair_ff;
        nxt_rdata[3:2]  = pair2lvl(cc_pair_ff);
        nxt_rdata[7:4]  = irq_vec_out;
        nxt_rdata[8]    = irq_req_out;
        nxt_rdata[9]    = wake_out;
      end
      default:     nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && bus_st_ff == BUS_WAIT) begin
      avs_readdata_out <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Priority registers
  // ------------------------------------------------------------------
  for (genvar r = 0; r < NUM_PRIO; r++) begin : g_prio
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        prio_ff[r] <= PRIO_RST; // RULE_05
      end else if (bus_done && avs_write_in && avs_byteenable_in[0] &&
                   avs_address_in == AW'(4 * r)) begin
        prio_ff[r] <= merge_prio(prio_ff[r], avs_writedata_in[7:0]); // RULE_04
      end
    end
  end

  // Vector x pair at flat bit 2x
  assign prio_flat = {prio_ff[3][3:0], prio_ff[2], prio_ff[1], prio_ff[0]}; // RULE_06

  // ------------------------------------------------------------------
  // Halt wake eligibility
  // ------------------------------------------------------------------
  always_comb begin
    wake_mask          = WAKE_FIXED; // RULE_17
    wake_mask[SPI_VEC] = spi_slave_in; // RULE_17
    wake_mask[ART_VEC] = art_ext_clk_in; // RULE_18
    if (FLASH_DEVICE && active_halt_in) begin
      wake_mask         = '0; // RULE_18
      wake_mask[TB_VEC] = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------------
  always_comb begin
    cand             = irq_req_in & irq_en_in; // RULE_20
    cand[UNUSED_VEC] = 1'b0; // RULE_15
    if (halt_mode_in) begin
      cand = cand & wake_mask;
    end
  end

  always_comb begin
    logic [1:0] lvl;
    lvl       = 2'h0;
    best_vld  = 1'b0;
    best_idx  = '0;
    best_lvl  = 3'h0;
    best_pair = PAIR_L3;
    // Downward scan with >= keeps the lowest index on ties
    for (int v = N_VEC - 1; v > TLI_VEC; v--) begin
      lvl = pair2lvl(prio_flat[2*v +: 2]); // RULE_02
      if (cand[v] && lvl > pair2lvl(cc_pair_ff) && // RULE_23 RULE_10
          (!best_vld || {1'b0, lvl} >= best_lvl)) begin // RULE_19 RULE_16
        best_vld  = 1'b1;
        best_idx  = VEC_W'(v);
        best_lvl  = {1'b0, lvl};
        best_pair = prio_flat[2*v +: 2];
      end
    end
    // Top-level vector outranks all; its stored pair is ignored
    if (cand[TLI_VEC]) begin // RULE_03 RULE_07
      best_vld  = 1'b1;
      best_idx  = VEC_W'(TLI_VEC);
      best_lvl  = LVL_TOP;
      best_pair = PAIR_L3; // RULE_09
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_req_out  <= 1'b0;
      irq_vec_out  <= '0;
      irq_addr_out <= VEC_BASE;
      irq_pair_ff  <= PAIR_L3;
      wake_out     <= 1'b0;
    end else begin
      irq_req_out  <= best_vld;
      irq_vec_out  <= best_idx;
      irq_addr_out <= vec_addr(best_idx); // RULE_15
      irq_pair_ff  <= best_pair;
      wake_out     <= |(irq_req_in & irq_en_in & wake_mask); // RULE_17
    end
  end

  // ------------------------------------------------------------------
  // Entry acknowledge and routine address
  // ------------------------------------------------------------------
  assign entry_ok = irq_entry_in & irq_req_out; // RULE_21

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_ack_out  <= '0;
      svc_addr_out <= VEC_RESET; // RULE_15
    end else begin
      irq_ack_out <= '0;
      if (entry_ok) begin
        irq_ack_out[irq_vec_out] <= 1'b1;
        svc_addr_out             <= irq_addr_out;
      end else if (cpu_evt_in.trap) begin
        svc_addr_out <= VEC_TRAP; // RULE_15
      end
    end
  end

  // ------------------------------------------------------------------
  // Current priority bits
  // ------------------------------------------------------------------
  always_comb begin
    nxt_cc_pair = cc_pair_ff;
    if (entry_ok) begin
      nxt_cc_pair = irq_pair_ff; // RULE_01 RULE_09
    end else if (cpu_evt_in.trap || cpu_evt_in.sim) begin
      nxt_cc_pair = PAIR_L3; // RULE_11 RULE_09 RULE_14
    end else if (cpu_evt_in.irq_return_instr || cpu_evt_in.pop_condition_codes) begin
      nxt_cc_pair = {cpu_evt_in.cc_val[CC_HI_BIT],
                     cpu_evt_in.cc_val[CC_LO_BIT]}; // RULE_12 RULE_14
    end else if (cpu_evt_in.irq_enable_instr || cpu_evt_in.halt || cpu_evt_in.wait_for_irq_instr) begin
      nxt_cc_pair = PAIR_L0; // RULE_11 RULE_14
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cc_pair_ff           <= PAIR_L3; // RULE_22
      jump_if_masked_out   <= 1'b1;
      jump_if_unmasked_out <= 1'b0;
    end else begin
      cc_pair_ff           <= nxt_cc_pair;
      jump_if_masked_out   <= (nxt_cc_pair == PAIR_L3); // RULE_13
      jump_if_unmasked_out <= (nxt_cc_pair != PAIR_L3); // RULE_13
    end
  end

  assign cur_prio_hi_out = cc_pair_ff[1];
  assign cur_prio_lo_out = cc_pair_ff[0];

endmodule

// >>> sim/nipu_properties.sv
// Port assertions for the nested interrupt priority unit
`timescale 1ns/100ps
module nipu_chk
  import nipu_pkg::*;
#(
  parameter int N_VEC = NUM_VEC
) (
  input wire logic             ref_clk_in,          // Clock
  input wire logic             rst_b_in,            // Reset
  input wire logic [N_VEC-1:0] irq_req_in,          // Flags
  input wire logic [N_VEC-1:0] irq_en_in,           // Enables
  input wire nipu_cpu_evt_s    cpu_evt_in,          // Events
  input wire logic             irq_entry_in,        // Entry
  input wire logic             irq_req_out,         // Request
  input wire logic [VEC_W-1:0] irq_vec_out,         // Vector
  input wire logic [15:0]      irq_addr_out,        // Address
  input wire logic [N_VEC-1:0] irq_ack_out,         // Ack
  input wire logic             cur_prio_hi_out,     // Pair hi
  input wire logic             cur_prio_lo_out,     // Pair lo
  input wire logic             jump_if_masked_out,  // Level 3
  input wire logic             jump_if_unmasked_out // Below 3
);
  logic [1:0]       pair;
  logic             take;
  logic             calm;
  logic [N_VEC-1:0] live_ff;
  assign pair = {cur_prio_hi_out, cur_prio_lo_out};
  assign take = irq_entry_in & irq_req_out;
  assign calm = ~take & ~cpu_evt_in.trap & ~cpu_evt_in.sim;
  // Eligible sources as the unit saw them
  always_ff @(posedge ref_clk_in) live_ff <= irq_req_in & irq_en_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_level: assert property ($rose(rst_b_in) |-> pair == PAIR_L3)
    else $error("level not 3 after reset");
  a_entry_ack: assert property (take |=> irq_ack_out == N_VEC'(1) << $past(irq_vec_out))
    else $error("wrong entry acknowledge");
  a_top_level: assert property (take && irq_vec_out == 0 |=> pair == PAIR_L3)
    else $error("top level entry not at level 3");
  a_disable_level: assert property (!take && (cpu_evt_in.sim || cpu_evt_in.trap)
    |=> pair == PAIR_L3)
    else $error("disable or trap did not set level 3");
  a_enable_level: assert property (calm && !cpu_evt_in.irq_return_instr && !cpu_evt_in.pop_condition_codes &&
    (cpu_evt_in.irq_enable_instr || cpu_evt_in.halt || cpu_evt_in.wait_for_irq_instr) |=> pair == PAIR_L0)
    else $error("enable, halt or wait did not set level 0");
  a_return_restore: assert property (calm && (cpu_evt_in.irq_return_instr || cpu_evt_in.pop_condition_codes)
    |=> pair == {$past(cpu_evt_in.cc_val[5]), $past(cpu_evt_in.cc_val[3])})
    else $error("popped level not restored");
  a_jump_flags: assert property (jump_if_masked_out == &pair && jump_if_unmasked_out == ~&pair)
    else $error("jump flags disagree with level");
  a_vector_address: assert property (irq_req_out |-> irq_addr_out == VEC_BASE - {irq_vec_out, 1'b0})
    else $error("vector address wrong");
  a_request_cause: assert property (irq_req_out |-> live_ff[irq_vec_out])
    else $error("request for a source not pending and enabled");
  a_top_first: assert property (irq_req_in[0] && irq_en_in[0] |=> irq_req_out && irq_vec_out == 0)
    else $error("top level source not requested first");
endmodule

// >>> sim/nipu_cpu_model.sv
// Behavioural CPU core and peripheral flags facing the priority unit
`timescale 1ns/100ps
module nipu_cpu_model
  import nipu_pkg::*;
(
  input  wire logic          clk_in,    // Clock
  input  wire logic          rst_b_in,  // Reset
  input  wire logic          req_in,    // Unit request
  input  wire logic [3:0]    vec_in,    // Requested vector
  input  wire logic [1:0]    pair_in,   // Current pair
  input  wire logic [1:0]    lag_in,    // Extra entry delay
  input  wire logic          ret_in,    // Routine return
  input  wire logic [13:0]   set_in,    // Flag set
  input  wire logic [13:0]   clr_in,    // Flag clear
  input  wire nipu_cpu_evt_s evt_in,    // Bench events
  output logic               entry_out, // Entry pulse
  output logic [13:0]        flag_out,  // Source flags
  output nipu_cpu_evt_s      evt_out    // Events to unit
);
  logic [1:0] stk_ff [8];
  logic [2:0] sp_ff;
  logic [2:0] cnt_ff;
  logic [2:0] top;
  logic       took;
  assign top = sp_ff - 3'h1;
  assign took = entry_out & req_in;
  // Source flag drops when its routine is entered
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) flag_out <= 14'h0000;
    else flag_out <= (flag_out | set_in) & ~clr_in & ~(took ? 14'h0001 << vec_in : 14'h0000);
  end
  // Entry after the request has stood past the lag
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      entry_out <= 1'b0;
      cnt_ff <= 3'h0;
    end else begin
      entry_out <= ~entry_out & req_in & (cnt_ff > {1'b0, lag_in});
      cnt_ff <= (entry_out | ~req_in) ? 3'h0 : cnt_ff + 3'h1;
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_ff <= 3'h0;
      evt_out <= '0;
    end else if (took) begin
      stk_ff[sp_ff] <= pair_in;
      sp_ff <= sp_ff + 3'h1;
      evt_out <= evt_in;
    end else if (ret_in) begin
      evt_out <= nipu_cpu_evt_s'({7'h02, 2'h3, stk_ff[top][1], 1'b0, stk_ff[top][0], 3'h0});
      sp_ff <= top;
    end else begin
      evt_out <= evt_in;
    end
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the nested interrupt priority unit
`timescale 1ns/100ps
module tb_top
  import nipu_pkg::*;
;
  logic          clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, ret = 1'b0;
  logic          hlt = 1'b0, ahlt = 1'b0, spis = 1'b0, artx = 1'b0;
  logic          req, ent, wake, hi, lo, wt, w, jm, jn;
  logic [4:0]    adr = 5'h00;
  logic [7:0]    wd = 8'h00, d;
  logic [3:0]    be = 4'h0, vec;
  logic [1:0]    lag = 2'h0;
  logic [13:0]   en = 14'h0000, set = 14'h0000, clr = 14'h0000, flg, ack;
  logic [15:0]   svc;
  logic [31:0]   rdat, lfsr = 32'h00011A5F;
  logic [7:0]    sh [4];
  logic [1:0]    ep [5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
  logic [31:0]   rd_q [$], ack_q [$];
  nipu_cpu_evt_s evt = '0, evo;
  int            n_mismatch = 0, comparisons = 0, n;
  always #2.5 clk = ~clk;
  nipu_top nipu_top_inst (
    .ref_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in({24'h000000, wd}), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .irq_req_in(flg), .irq_en_in(en),
    .cpu_evt_in(evo), .irq_entry_in(ent), .halt_mode_in(hlt), .active_halt_in(ahlt),
    .spi_slave_in(spis), .art_ext_clk_in(artx), .irq_req_out(req), .irq_vec_out(vec),
    .irq_addr_out(), .irq_ack_out(ack), .svc_addr_out(svc), .wake_out(wake),
    .cur_prio_hi_out(hi), .cur_prio_lo_out(lo), .jump_if_masked_out(jm),
    .jump_if_unmasked_out(jn));
  nipu_cpu_model nipu_cpu_model_inst (
    .clk_in(clk), .rst_b_in(rst_b), .req_in(req), .vec_in(vec), .pair_in({hi, lo}),
    .lag_in(lag), .ret_in(ret), .set_in(set), .clr_in(clr), .evt_in(evt),
    .entry_out(ent), .flag_out(flg), .evt_out(evo));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [7:0] merge(input logic [7:0] o, nv, input int r);
    for (int i = 0; i < 8; i += 2)
      if (nv[i+:2] != PAIR_L0) o[i+:2] = nv[i+:2];
    if (r == 3) o[7:4] = 4'hF;
    return o;
  endfunction
  function automatic logic [1:0] pr(input int v);
    return sh[v / 4][2 * (v % 4) +: 2];
  endfunction
  function automatic int lvl(input logic [1:0] p);
    return (p == PAIR_L3) ? 3 : (p == PAIR_L0) ? 0 : (p == PAIR_L1) ? 1 : 2;
  endfunction
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic wv, input logic [4:0] a, input logic [7:0] dv, input logic [3:0] b);
    rd <= ~wv;
    wr <= wv;
    adr <= a;
    wd <= dv;
    be <= b;
    @(posedge clk);
    for (int i = 0; i < 20 && wt !== 1'b0; i++) @(posedge clk);
    if (wt !== 1'b0) n_mismatch++;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'h0);
  endtask
  task automatic wrp(input int r, input logic [7:0] v);
    bus(1'b1, 5'(4 * r), v, 4'h1);
    sh[r] = merge(sh[r], v, r);
  endtask
  task automatic pset(input logic [13:0] m);
    set <= m;
    @(posedge clk);
    set <= 14'h0000;
    @(posedge clk);
  endtask
  task automatic wack();
    lag <= 2'(rnd());
    for (int i = 0; i < 60 && ack === 14'h0000; i++) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic pret();
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic ev(input nipu_cpu_evt_s e, input logic [1:0] p);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
    chk({30'h0, hi, lo}, {30'h0, p});
    chk({30'h0, jm, jn}, {30'h0, p == PAIR_L3, p != PAIR_L3});
  endtask
  task automatic test_done();
    if (ack_q.size() != 0 || rd_q.size() != 0) n_mismatch++;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Results as they appear
  always @(posedge clk) begin
    if (rd && wt === 1'b0) chk(rdat, rd_q.pop_front());
    if (ack !== 14'h0000) chk({svc, hi, lo, ack}, ack_q.pop_front());
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 4; r++) begin
      sh[r] = PRIO_RST;
      rdchk(5'(4 * r), 32'h000000FF);
    end
    rdchk(ADDR_STATUS, 32'h0000000F);
    rdchk(5'h14, 32'h00000000);
    for (int k = 0; k < 12; k++) begin
      wrp(k % 4, 8'(rnd()));
      rdchk(5'(4 * (k % 4)), {24'h000000, sh[k % 4]});
    end
    wrp(0, 8'hCF);
    wrp(0, 8'h64);
    bus(1'b1, ADDR_PRIO0, 8'h00, 4'h0);
    bus(1'b1, 5'h14, 8'h00, 4'h1);
    rdchk(ADDR_PRIO0, 32'h00000044);
    en <= 14'h3FFF;
    hlt <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      spis <= (k == 1);
      artx <= (k == 1);
      ahlt <= (k == 2);
      for (int v = 1; v < 14; v++) begin
        w = (k == 2) ? (v == 1) : (v < 6 || ((v == 7 || v == 13) && k == 1));
        pset(14'h0001 << v);
        repeat (2) @(posedge clk);
        chk({31'h0, wake}, {31'h0, w});
        clr <= 14'h0001 << v;
        @(posedge clk);
        clr <= 14'h0000;
        repeat (2) @(posedge clk);
      end
    end
    hlt <= 1'b0;
    ahlt <= 1'b0;
    ack_q.push_back({16'hFFFA, 2'h3, 14'h0001});
    pset(14'h0001);
    wack();
    for (int i = 0; i < 5; i++) ev(nipu_cpu_evt_s'(15'h0001 << (14 - i)), ep[i]);
    chk({16'h0, svc}, {16'h0, VEC_TRAP});
    d = 8'(rnd());
    ev(nipu_cpu_evt_s'({7'h01, d}), {d[5], d[3]});
    pret();
    ev(nipu_cpu_evt_s'(15'h4000), PAIR_L0);
    for (int r = 0; r < 4; r++) wrp(r, 8'(rnd()));
    en <= 14'h3DFF;
    ack_q.push_back({16'hFFFA, 2'h3, 14'h0001});
    for (int l = 3; l > 0; l--)
      for (int v = 1; v < 14; v++)
        if (v != 6 && v != 9 && lvl(pr(v)) == l)
          ack_q.push_back({16'hFFFA - 16'(2 * v), pr(v), 14'h0001 << v});
    n = ack_q.size();
    pset(14'h3FBF);
    repeat (n) begin
      wack();
      pret();
    end
    ack_q.push_back({16'hFFE8, pr(9), 14'h0200});
    en <= 14'h3FFF;
    wack();
    pret();
    wrp(0, {sh[0][7:6], 2'h1, sh[0][3:0]});
    ack_q.push_back({16'hFFF6, 2'h1, 14'h0004});
    pset(14'h0004);
    wack();
    pset(14'h0004);
    repeat (6) @(posedge clk);
    ack_q.push_back({16'hFFF6, 2'h0, 14'h0004});
    wrp(0, {sh[0][7:6], 2'h0, sh[0][3:0]});
    wack();
    pret();
    pret();
    test_done();
  end
  initial begin
    #200us;
    n_mismatch++;
    test_done();
  end
endmodule
bind nipu_top nipu_chk #(.N_VEC(N_VEC)) nipu_chk_inst (.*);
